// ### src/ssm_stop_sequencer.sv
// Purpose: stop-mode sequencer for a linear servo amplifier
// Assumes: all inputs synchronous to clock; motor_stopped from speed logic
// Notes:   restart-time settings captured on restart_load
// How it works
// - selector 0 brakes dynamically, then holds the dynamic brake state.
// - selector 1 brakes dynamically, then coasts with power stage off.
// - selector 2 coasts to rest and stays coasting, power stage off.
// - servo-on going inactive starts the selected stop sequence.
// - group one alarm runs the same sequence as servo-off.
// - option 0: group two zeroes speed until stopped, then brake or coast.
// - option 1: group two alarm stops like group one.
// - in force control the option is ignored; selector alone decides.
// - dynamic brake hold gives no braking force at rest or crawl.
// - flag power interruption; hold time 20..1000 ms, default 20, immediate.
// - supply back before hold time keeps the servo running.
// - supply absent when elapsed reaches hold time turns servo off.
// - control supply loss ignores hold time, acts as power-off.
// - undervoltage during interruption ignores hold time, alarm handled.
// - overspeed alarm above speed limit; 1..100 x100 mm/s, default 50.
`timescale 1ns/100ps
`default_nettype none
module ssm_stop_sequencer #(
    parameter int unsigned TICK_CYC = ssm_pkg::CYC_PER_MS,
    parameter int unsigned SPD_W    = ssm_pkg::SPD_W
) (
    input  wire logic                             clock,
    input  wire logic                             reset,
    input  wire logic                             restart_load,
    input  wire ssm_pkg::ssm_cfg_t                cfg_in,
    input  wire logic [ssm_pkg::HOLD_W-1:0]       power_cut_hold_time,
    input  wire logic [ssm_pkg::SPD_LIM_W-1:0]    max_speed_limit,
    input  wire ssm_pkg::ssm_ctrl_mode_t          ctrl_mode,
    input  wire logic                             servo_on,
    input  wire logic                             group_one_alarm,
    input  wire logic                             group_two_alarm,
    input  wire logic                             undervoltage_alarm,
    input  wire logic                             main_supply_ok,
    input  wire logic                             control_supply_ok,
    input  wire logic                             motor_stopped,
    input  wire logic [SPD_W-1:0]                 speed_100mms,
    output ssm_pkg::ssm_drive_t                   drive,
    output logic                                  power_cut_flag,
    output logic                                  overspeed_alarm,
    output ssm_pkg::ssm_state_t                   state,
    output logic [ssm_pkg::HOLD_W-1:0]            cut_elapsed_ms,
    output ssm_pkg::ssm_cfg_t                     cfg_active,
    output logic [ssm_pkg::SPD_LIM_W-1:0]         speed_limit_active
);
    // refused at elaboration: the limit must fit the speed word
    if (SPD_W < ssm_pkg::SPD_LIM_W) begin : g_spd_chk
        $error("ssm_stop_sequencer: SPD_W too narrow");
    end

    ssm_pkg::ssm_state_t           st_ff;
    ssm_pkg::ssm_state_t           nxt_st;
    ssm_pkg::ssm_cfg_t             cfg_ff;
    logic [ssm_pkg::SPD_LIM_W-1:0] lim_ff;
    logic [ssm_pkg::HOLD_W-1:0]    hold_eff;
    logic                          ovs_ff;
    ssm_pkg::ssm_drive_t           drv_ff;
    ssm_pkg::ssm_drive_t           nxt_drv;

    logic tick;
    logic cut_active;
    logic cut_expired;

    // settings that act only after restart
    ssm_pkg::ssm_cfg_t             nxt_cfg;
    logic [ssm_pkg::SPD_LIM_W-1:0] nxt_lim;
    logic [ssm_pkg::SPD_LIM_W-1:0] lim_clamped;
    logic [1:0]                    sel_clamped;

    assign sel_clamped = (cfg_in.stop_method_select > ssm_pkg::STOP_COAST)
                       ? ssm_pkg::STOP_DEFAULT : cfg_in.stop_method_select;
    assign lim_clamped = (max_speed_limit < ssm_pkg::SPD_LIM_MIN) ? ssm_pkg::SPD_LIM_MIN :
                         (max_speed_limit > ssm_pkg::SPD_LIM_MAX) ? ssm_pkg::SPD_LIM_MAX :
                         max_speed_limit;
    assign nxt_cfg = restart_load ? '{stop_method_select: sel_clamped,
                                      alarm_stop_option:  cfg_in.alarm_stop_option} : cfg_ff;
    assign nxt_lim = restart_load ? lim_clamped : lim_ff;

    // hold time is immediate; out-of-range values clamp
    assign hold_eff = (power_cut_hold_time < ssm_pkg::HOLD_MIN) ? ssm_pkg::HOLD_MIN :
                      (power_cut_hold_time > ssm_pkg::HOLD_MAX) ? ssm_pkg::HOLD_MAX :
                      power_cut_hold_time;

    ssm_ms_tick #(
        .CYC (TICK_CYC)
    ) u_tick (
        .clock (clock),
        .reset (reset),
        .tick  (tick)
    );

    ssm_power_cut u_cut (
        .clock          (clock),
        .reset          (reset),
        .tick           (tick),
        .main_supply_ok (main_supply_ok),
        .hold_ms        (hold_eff),
        .cut_active     (cut_active),
        .cut_expired    (cut_expired),
        .elapsed_ms     (cut_elapsed_ms)
    );

    // stop causes
    logic force_mode;
    logic gr2_zero;
    logic gr2_as_gr1;
    logic power_off;
    logic sel_stop;
    logic zero_stop;
    logic sel_db;
    logic rest_db;

    assign force_mode = (ctrl_mode == ssm_pkg::CTRL_FORCE);
    // option only meaningful in position and speed control
    assign gr2_as_gr1 = group_two_alarm &&
                        (force_mode || cfg_ff.alarm_stop_option == ssm_pkg::ALM_OPT_GR1);
    assign gr2_zero   = group_two_alarm && !gr2_as_gr1;
    // short cuts keep running; expiry, control loss or undervoltage end it
    assign power_off  = cut_expired
                     || !control_supply_ok
                     || (cut_active && undervoltage_alarm);
    assign sel_stop   = !servo_on || group_one_alarm || gr2_as_gr1 || power_off
                     || undervoltage_alarm;
    assign zero_stop  = gr2_zero && !sel_stop;
    assign sel_db     = (cfg_ff.stop_method_select != ssm_pkg::STOP_COAST);
    assign rest_db    = (cfg_ff.stop_method_select == ssm_pkg::STOP_DB_HOLD);
    logic any_stop;
    assign any_stop   = sel_stop || gr2_zero;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ssm_pkg::ST_RUN: begin
                if (sel_stop) begin
                    nxt_st = sel_db ? ssm_pkg::ST_DB_STOP : ssm_pkg::ST_COAST_STOP;
                end else if (zero_stop) begin
                    nxt_st = ssm_pkg::ST_ZERO_SPD;
                end
            end
            ssm_pkg::ST_ZERO_SPD: begin
                // a harder cause overrides the zero-speed stop
                if (sel_stop) begin
                    nxt_st = sel_db ? ssm_pkg::ST_DB_STOP : ssm_pkg::ST_COAST_STOP;
                end else if (motor_stopped) begin
                    nxt_st = rest_db ? ssm_pkg::ST_DB_HOLD : ssm_pkg::ST_COAST;
                end
            end
            ssm_pkg::ST_DB_STOP: begin
                if (motor_stopped) begin
                    nxt_st = rest_db ? ssm_pkg::ST_DB_HOLD : ssm_pkg::ST_COAST;
                end
            end
            ssm_pkg::ST_COAST_STOP: begin
                if (motor_stopped) begin
                    nxt_st = ssm_pkg::ST_COAST;
                end
            end
            ssm_pkg::ST_DB_HOLD,
            ssm_pkg::ST_COAST: begin
                if (!any_stop) begin
                    nxt_st = ssm_pkg::ST_RUN;
                end
            end
            default: nxt_st = ssm_pkg::ST_DB_HOLD;
        endcase
    end

    // brake relay stays closed in hold; at rest it yields no force anyway
    always_comb begin
        nxt_drv = '{power_on: 1'b0, dynamic_brake: 1'b0, zero_speed_ref: 1'b0, servo_off: 1'b1};
        unique case (nxt_st)
            ssm_pkg::ST_RUN: begin
                nxt_drv.power_on  = 1'b1;
                nxt_drv.servo_off = 1'b0;
            end
            ssm_pkg::ST_ZERO_SPD: begin
                nxt_drv.power_on       = 1'b1;
                nxt_drv.zero_speed_ref = 1'b1;
            end
            ssm_pkg::ST_DB_STOP: nxt_drv.dynamic_brake = 1'b1;
            ssm_pkg::ST_DB_HOLD: nxt_drv.dynamic_brake = 1'b1;
            ssm_pkg::ST_COAST_STOP,
            ssm_pkg::ST_COAST: nxt_drv.dynamic_brake = 1'b0;
            default: nxt_drv.dynamic_brake = 1'b1;
        endcase
    end

    logic nxt_ovs;
    // sticky until reset, like any drive alarm
    assign nxt_ovs = ovs_ff || (speed_100mms > SPD_W'(lim_ff));

    always_ff @(posedge clock) begin
        if (reset) begin
            st_ff  <= ssm_pkg::ST_COAST;
            cfg_ff <= '{stop_method_select: ssm_pkg::STOP_DEFAULT,
                        alarm_stop_option:  ssm_pkg::ALM_OPT_ZERO};
            lim_ff <= ssm_pkg::SPD_LIM_DEFAULT;
            ovs_ff <= 1'b0;
            drv_ff <= '{power_on: 1'b0, dynamic_brake: 1'b0, zero_speed_ref: 1'b0,
                        servo_off: 1'b1};
        end else begin
            st_ff  <= nxt_st;
            cfg_ff <= nxt_cfg;
            lim_ff <= nxt_lim;
            ovs_ff <= nxt_ovs;
            drv_ff <= nxt_drv;
        end
    end

    assign drive              = drv_ff;
    assign state              = st_ff;
    assign power_cut_flag     = cut_active;
    assign overspeed_alarm    = ovs_ff;
    assign cfg_active         = cfg_ff;
    assign speed_limit_active = lim_ff;
endmodule
`default_nettype wire

// ### src/ssm_pkg.sv
// Purpose: shared constants and types for the servo stop-mode sequencer
// Assumes: 200 MHz clock, millisecond tick derived inside the block
// Notes:   parameter values use the drive's setting units
package ssm_pkg;

    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned TICK_MS        = 1;
    localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000 * TICK_MS;

    localparam int unsigned HOLD_W         = 10;
    localparam logic [9:0]  HOLD_MIN       = 10'h014;
    localparam logic [9:0]  HOLD_MAX       = 10'h3E8;
    localparam logic [9:0]  HOLD_DEFAULT   = 10'h014;

    localparam int unsigned SPD_LIM_W      = 7;
    localparam logic [6:0]  SPD_LIM_MIN    = 7'h01;
    localparam logic [6:0]  SPD_LIM_MAX    = 7'h64;
    localparam logic [6:0]  SPD_LIM_DEFAULT = 7'h32;
    localparam int unsigned SPD_W          = 16;

    localparam logic [1:0]  STOP_DB_HOLD   = 2'h0;
    localparam logic [1:0]  STOP_DB_COAST  = 2'h1;
    localparam logic [1:0]  STOP_COAST     = 2'h2;
    localparam logic [1:0]  STOP_DEFAULT   = 2'h0;

    localparam logic        ALM_OPT_ZERO   = 1'h0;
    localparam logic        ALM_OPT_GR1    = 1'h1;

    typedef enum logic [1:0] {
        CTRL_POSITION = 2'h0,
        CTRL_SPEED    = 2'h1,
        CTRL_FORCE    = 2'h2
    } ssm_ctrl_mode_t;

    // gray along run -> stopping -> rest
    typedef enum logic [2:0] {
        ST_RUN       = 3'h0,
        ST_ZERO_SPD  = 3'h1,
        ST_DB_STOP   = 3'h3,
        ST_COAST_STOP = 3'h2,
        ST_DB_HOLD   = 3'h6,
        ST_COAST     = 3'h7
    } ssm_state_t;

    typedef struct packed {
        logic [1:0] stop_method_select;
        logic       alarm_stop_option;
    } ssm_cfg_t;

    typedef struct packed {
        logic power_on;
        logic dynamic_brake;
        logic zero_speed_ref;
        logic servo_off;
    } ssm_drive_t;

endpackage

// ### src/ssm_ms_tick.sv
// Purpose: millisecond tick from the control clock
// Assumes: CYC parameter above one
// Notes:   free running from reset
`timescale 1ns/100ps
`default_nettype none
module ssm_ms_tick #(
    parameter int unsigned CYC = ssm_pkg::CYC_PER_MS
) (
    input  wire logic clock,
    input  wire logic reset,
    output logic      tick
);
    // refused at elaboration: a shorter period leaves the counter without bits
    if (CYC < 2) begin : g_cyc_chk
        $error("ssm_ms_tick: CYC must be at least 2");
    end

    localparam int unsigned CW = $clog2(CYC);
    localparam logic [CW-1:0] LAST = CW'(CYC - 1);

    logic [CW-1:0] cnt_ff;
    logic          wrap;
    logic [CW-1:0] nxt_cnt;

    assign wrap    = (cnt_ff == LAST);
    assign nxt_cnt = wrap ? '0 : cnt_ff + CW'(1);
    assign tick    = wrap;

    always_ff @(posedge clock) begin
        if (reset) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

// ### src/ssm_power_cut.sv
// Purpose: instantaneous power-cut timer against the hold time
// Assumes: main_supply_ok synchronous, tick one cycle per ms
// Notes:   hold time read live, so changes act at once
`timescale 1ns/100ps
`default_nettype none
module ssm_power_cut (
    input  wire logic                         clock,
    input  wire logic                         reset,
    input  wire logic                         tick,
    input  wire logic                         main_supply_ok,
    input  wire logic [ssm_pkg::HOLD_W-1:0]   hold_ms,
    output logic                              cut_active,
    output logic                              cut_expired,
    output logic [ssm_pkg::HOLD_W-1:0]        elapsed_ms
);
    logic [ssm_pkg::HOLD_W-1:0] cnt_ff;
    logic                       lost_ff;
    logic                       exp_ff;
    logic                       lost_edge;
    logic                       at_hold;
    logic [ssm_pkg::HOLD_W-1:0] nxt_cnt;
    logic                       nxt_exp;

    assign lost_edge = !main_supply_ok && !lost_ff;
    assign at_hold   = (cnt_ff >= hold_ms);
    // restart on each loss, count per tick, saturate
    assign nxt_cnt   = lost_edge ? '0 :
                       (!main_supply_ok && tick && !at_hold) ? cnt_ff + ssm_pkg::HOLD_W'(1) : cnt_ff;
    // expiry sticks until supply returns: servo off once reached
    assign nxt_exp   = main_supply_ok ? 1'b0 : (exp_ff || (!lost_edge && at_hold));

    always_ff @(posedge clock) begin
        if (reset) begin
            cnt_ff  <= '0;
            lost_ff <= 1'b0;
            exp_ff  <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            lost_ff <= !main_supply_ok;
            exp_ff  <= nxt_exp;
        end
    end

    assign cut_active  = lost_ff;
    assign cut_expired = exp_ff;
    assign elapsed_ms  = cnt_ff;
endmodule
`default_nettype wire

// ### tb/ssm_stop_sequencer_assertions.sv
// Purpose: port-level checks for the stop sequencer
// Assumes: bound into ssm_stop_sequencer, one clock domain
// Notes:   hold time kept in range by the bench, so no clamp here
`timescale 1ns/100ps
`default_nettype none
module ssm_stop_sequencer_assertions #(
    parameter int unsigned SPD_W = ssm_pkg::SPD_W
) (
    input wire logic                    clock,
    input wire logic                    reset,
    input wire logic                    restart_load,
    input wire logic [9:0]              power_cut_hold_time,
    input wire ssm_pkg::ssm_ctrl_mode_t ctrl_mode,
    input wire logic                    servo_on,
    input wire logic                    group_one_alarm,
    input wire logic                    group_two_alarm,
    input wire logic                    undervoltage_alarm,
    input wire logic                    main_supply_ok,
    input wire logic                    control_supply_ok,
    input wire logic                    motor_stopped,
    input wire logic [SPD_W-1:0]        speed_100mms,
    input wire ssm_pkg::ssm_drive_t     drive,
    input wire logic                    power_cut_flag,
    input wire logic                    overspeed_alarm,
    input wire ssm_pkg::ssm_state_t     state,
    input wire logic [9:0]              cut_elapsed_ms,
    input wire ssm_pkg::ssm_cfg_t       cfg_active,
    input wire logic [6:0]              speed_limit_active
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    logic [1:0] sel;
    logic       run;
    logic       calm;
    assign sel  = cfg_active.stop_method_select;
    assign run  = (state == ssm_pkg::ST_RUN);
    assign calm = servo_on & ~group_one_alarm & ~undervoltage_alarm & control_supply_ok
                  & ~overspeed_alarm;
    AST_SEL_DB: assert property (
        run && (!servo_on || group_one_alarm) && sel != ssm_pkg::STOP_COAST |=>
        state == ssm_pkg::ST_DB_STOP && drive.dynamic_brake && !drive.power_on)
        else $error("selector stop did not brake");
    AST_SEL_COAST: assert property (
        run && (!servo_on || group_one_alarm) && sel == ssm_pkg::STOP_COAST |=>
        state == ssm_pkg::ST_COAST_STOP && !drive.dynamic_brake && !drive.power_on)
        else $error("coast stop wrong");
    AST_DB_END: assert property (
        state == ssm_pkg::ST_DB_STOP && motor_stopped |=> state ==
        (sel == ssm_pkg::STOP_DB_COAST ? ssm_pkg::ST_COAST : ssm_pkg::ST_DB_HOLD))
        else $error("wrong state after braking");
    AST_ZERO: assert property (
        run && calm && main_supply_ok && group_two_alarm && !cfg_active.alarm_stop_option
        && ctrl_mode != ssm_pkg::CTRL_FORCE |=> state == ssm_pkg::ST_ZERO_SPD
        && drive.zero_speed_ref && drive.power_on) else $error("no zero-speed stop");
    AST_GRP_TWO_SEL: assert property (
        run && group_two_alarm && (cfg_active.alarm_stop_option
        || ctrl_mode == ssm_pkg::CTRL_FORCE) |=>
        state inside {ssm_pkg::ST_DB_STOP, ssm_pkg::ST_COAST_STOP})
        else $error("group two did not use selector stop");
    AST_CUT_FLAG: assert property (
        !main_supply_ok |=> power_cut_flag) else $error("cut not flagged");
    AST_RIDE: assert property (
        run && calm && !group_two_alarm && cut_elapsed_ms < power_cut_hold_time |=> run)
        else $error("servo left run before hold time");
    AST_CUT_OFF: assert property (
        run && power_cut_flag && !main_supply_ok && cut_elapsed_ms >= power_cut_hold_time
        |-> ##[1:3] !run) else $error("servo kept on after hold time");
    AST_OVERSPEED: assert property (
        speed_100mms > SPD_W'(speed_limit_active) |-> ##[1:2] overspeed_alarm)
        else $error("overspeed missed");
    AST_RESTART: assert property (
        !restart_load |=> $stable(cfg_active) && $stable(speed_limit_active))
        else $error("setting changed without restart");
    COV_ZERO: cover property (state == ssm_pkg::ST_ZERO_SPD);
    COV_HOLD: cover property (state == ssm_pkg::ST_DB_HOLD);
    COV_OVS: cover property ($rose(overspeed_alarm));
endmodule
`default_nettype wire

// ### tb/ssm_motor_model.sv
// Purpose: motor behind the sequencer, stops after a decel delay
// Assumes: slow picks a long coast-down so stop states last
// Notes:   moving whenever powered without a zero speed reference
`timescale 1ns/100ps
`default_nettype none
module ssm_motor_model (
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic                slow,
    input  wire ssm_pkg::ssm_drive_t drive,
    output logic                     motor_stopped
);
    logic [5:0] cnt_ff;
    logic       pushed;
    assign pushed = drive.power_on & ~drive.zero_speed_ref;
    always_ff @(posedge clock) begin
        if (reset | pushed) begin
            cnt_ff <= slow ? 6'h28 : 6'h03;
        end else if (cnt_ff != 6'h00) begin
            cnt_ff <= cnt_ff - 6'h01;
        end
    end
    assign motor_stopped = (cnt_ff == 6'h00);
endmodule
`default_nettype wire

// ### tb/tb_ssm_stop_sequencer.sv
// Purpose: self-checking bench for the stop sequencer
// Assumes: short ms tick, motor model on the far side
// Notes:   selector, mode, hold and limit drawn from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module tb_ssm_stop_sequencer;
    localparam int TCYC = 4;
    logic                    clock = 1'b0;
    logic                    reset = 1'b1;
    logic                    restart_load = 1'b0;
    ssm_pkg::ssm_cfg_t       cfg_in = 3'h0;
    logic [9:0]              power_cut_hold_time = ssm_pkg::HOLD_DEFAULT;
    logic [6:0]              max_speed_limit = ssm_pkg::SPD_LIM_DEFAULT;
    ssm_pkg::ssm_ctrl_mode_t ctrl_mode = ssm_pkg::CTRL_POSITION;
    logic                    servo_on = 1'b0;
    logic                    group_one_alarm = 1'b0;
    logic                    group_two_alarm = 1'b0;
    logic                    undervoltage_alarm = 1'b0;
    logic                    main_supply_ok = 1'b1;
    logic                    control_supply_ok = 1'b1;
    logic [15:0]             speed_100mms = 16'h0000;
    logic                    slow = 1'b0;
    logic                    motor_stopped;
    ssm_pkg::ssm_drive_t     drive;
    logic                    power_cut_flag;
    logic                    overspeed_alarm;
    ssm_pkg::ssm_state_t     state;
    logic [9:0]              cut_elapsed_ms;
    ssm_pkg::ssm_cfg_t       cfg_active;
    logic [6:0]              speed_limit_active;
    int                      error_cnt = 0;
    int                      checks = 0;
    integer                  seed = 32'hE3D927A1;
    logic [1:0]              cur_sel = 2'h0;
    int                      lim;

    ssm_stop_sequencer #(.TICK_CYC(TCYC)) u_ssm_stop_sequencer (
        .clock, .reset, .restart_load, .cfg_in, .power_cut_hold_time, .max_speed_limit,
        .ctrl_mode, .servo_on, .group_one_alarm, .group_two_alarm, .undervoltage_alarm,
        .main_supply_ok, .control_supply_ok, .motor_stopped, .speed_100mms, .drive,
        .power_cut_flag, .overspeed_alarm, .state, .cut_elapsed_ms, .cfg_active,
        .speed_limit_active);
    ssm_motor_model u_ssm_motor_model (.clock, .reset, .slow, .drive, .motor_stopped);

    always #2.5 clock = ~clock;

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_st(input ssm_pkg::ssm_state_t st, input int n, input string msg);
        int i;
        for (i = 0; i < n && state !== st; i++) begin
            step(1);
        end
        chk(state === st, msg);
    endtask
    function automatic ssm_pkg::ssm_state_t exp_stop(input logic [1:0] s, input int c);
        if (c == 6) return ssm_pkg::ST_ZERO_SPD;
        return (s == ssm_pkg::STOP_COAST) ? ssm_pkg::ST_COAST_STOP : ssm_pkg::ST_DB_STOP;
    endfunction
    function automatic ssm_pkg::ssm_state_t exp_rest(input logic [1:0] s);
        return (s == 2'h1 || s == 2'h2) ? ssm_pkg::ST_COAST : ssm_pkg::ST_DB_HOLD;
    endfunction
    task automatic do_reset();
        reset = 1'b1;
        step(4);
        chk(state === ssm_pkg::ST_COAST && drive === 4'h1 && !overspeed_alarm, "reset");
        chk(cfg_active === 3'h0 && speed_limit_active === 7'h32, "reset cfg");
        reset = 1'b0;
    endtask
    task automatic load_cfg(input logic [1:0] s, input logic o, input logic [6:0] l);
        cfg_in = {s, o};
        max_speed_limit = l;
        cur_sel = s;
        restart_load = 1'b1;
        step(1);
        restart_load = 1'b0;
    endtask
    task automatic go_run();
        {servo_on, group_one_alarm, group_two_alarm, undervoltage_alarm} = 4'h8;
        {main_supply_ok, control_supply_ok} = 2'h3;
        wait_st(ssm_pkg::ST_RUN, 100, "back to run");
        step(2);
    endtask
    task automatic stop_case(input logic [1:0] s, input int c);
        load_cfg(s, c == 2, 7'h32);
        go_run();
        ctrl_mode = ($random(seed) & 1) ? ssm_pkg::CTRL_SPEED : ssm_pkg::CTRL_POSITION;
        slow = 1'($random(seed));
        case (c)
            0: servo_on = 1'b0;
            1: group_one_alarm = 1'b1;
            4: undervoltage_alarm = 1'b1;
            5: control_supply_ok = 1'b0;
            default: group_two_alarm = 1'b1;
        endcase
        if (c == 3) ctrl_mode = ssm_pkg::CTRL_FORCE;
        step(1);
        chk(state === exp_stop(s, c), "stop entry");
        wait_st(exp_rest(s), 100, "rest state");
        step(4);
        chk(state === exp_rest(s) && drive.power_on === 1'b0, "rest held");
        chk(drive.dynamic_brake === (exp_rest(s) == ssm_pkg::ST_DB_HOLD), "rest brake");
    endtask
    task automatic cut_case(input int hold, input int mode);
        go_run();
        power_cut_hold_time = 10'(hold);
        main_supply_ok = 1'b0;
        step(1);
        chk(power_cut_flag === 1'b1, "cut flag");
        step((hold - 3) * TCYC);
        chk(state === ssm_pkg::ST_RUN, "ride through");
        chk(cut_elapsed_ms === 10'(hold - 3), "cut timer");
        if (mode == 0) begin
            main_supply_ok = 1'b1;
            step(8 * TCYC);
            chk(state === ssm_pkg::ST_RUN, "supply back");
        end
        if (mode == 1) wait_st(exp_stop(cur_sel, 0), 6 * TCYC, "cut expiry");
        undervoltage_alarm = (mode == 2);
        control_supply_ok = (mode != 3);
        step(1);
        if (mode == 2) chk(state === exp_stop(cur_sel, 0), "undervoltage");
        if (mode == 3) chk(state === exp_stop(cur_sel, 0), "control loss");
        main_supply_ok = 1'b1;
    endtask

    initial begin
        do_reset();
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 7; c++) begin
                stop_case(2'(s), c);
            end
        end
        $display("test stop_modes done");
        load_cfg(2'($unsigned($random(seed)) % 3), 1'b0, 7'h32);
        for (int m = 0; m < 4; m++) begin
            cut_case(20, m);
            cut_case(20 + $unsigned($random(seed)) % 21, m);
        end
        $display("test power_cut done");
        lim = 1 + $unsigned($random(seed)) % 100;
        load_cfg(cur_sel, 1'b0, 7'(lim));
        max_speed_limit = 7'(lim) ^ 7'h01;
        speed_100mms = 16'(lim);
        step(3);
        chk(speed_limit_active === 7'(lim) && overspeed_alarm === 1'b0, "limit");
        speed_100mms = 16'(lim + 1);
        step(3);
        chk(overspeed_alarm === 1'b1, "overspeed");
        speed_100mms = 16'h0000;
        do_reset();
        $display("test overspeed done");
        close_out();
    end
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end
endmodule

bind ssm_stop_sequencer ssm_stop_sequencer_assertions #(.SPD_W(SPD_W)) u_ssm_asrt (
    .clock, .reset, .restart_load, .power_cut_hold_time, .ctrl_mode, .servo_on,
    .group_one_alarm, .group_two_alarm, .undervoltage_alarm, .main_supply_ok,
    .control_supply_ok, .motor_stopped, .speed_100mms, .drive, .power_cut_flag,
    .overspeed_alarm, .state, .cut_elapsed_ms, .cfg_active, .speed_limit_active);
`default_nettype wire
